// File: design/gp_pkg.sv
// Constants shared by the eight-pin port and its input stage
package gp_pkg;
  localparam int GP_PINS = 8;
  localparam int GP_ADDR_W = 4;
  localparam int GP_DATA_W = 8;
  // Register addresses
  localparam logic [3:0] GP_OFF_DIR = 4'h0;
  localparam logic [3:0] GP_OFF_LEVEL = 4'h1;
  localparam logic [3:0] GP_OFF_IEN = 4'h2;
  localparam logic [3:0] GP_OFF_CTRL = 4'h3;
  localparam logic [3:0] GP_OFF_IST = 4'h4;
  localparam logic [3:0] GP_OFF_IMASK = 4'h5;
  // Control register fields
  localparam int GP_CTRL_LATCH = 0;
  localparam int GP_CTRL_MODEM = 1;
  localparam int GP_CTRL_SOFT_RESET_TRIGGER = 3;
  localparam logic [7:0] GP_CTRL_WMASK = 8'h03;
  // Interrupt status fields
  localparam int GP_IST_PIN = 0;
  localparam int GP_IST_MODEM = 1;
  localparam logic [1:0] GP_IST_RESET = 2'h0;
  // Pin roles in modem mode
  localparam int GP_RI_PIN = 7;
  localparam int GP_CD_PIN = 6;
  localparam int GP_DTR_PIN = 5;
  localparam int GP_DSR_PIN = 4;
  localparam logic [7:0] GP_ALL_MASK = 8'hFF;
  localparam logic [7:0] GP_LOW_MASK = 8'h0F;
  localparam logic [7:0] GP_MODEM_IN_MASK = 8'hD0;
  localparam logic [7:0] GP_ZERO = 8'h00;
endpackage

// File: design/gp_pin_if.sv
// Synchronised pin levels and change flags between the input stage and the port
interface gp_pin_if;
  logic [7:0] level;
  logic [7:0] change;
  modport src (output level, output change);
  modport dst (input level, input change);
endinterface

// File: design/gp_sync.sv
// Pin input synchroniser and change detector
module gp_sync import gp_pkg::*; #(
  parameter int PINS = GP_PINS
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [7:0] pin_in,
  gp_pin_if.src pins
);
  logic [7:0] meta;
  logic [7:0] stable;
  logic [7:0] prev;
  logic [7:0] next_meta;
  logic [7:0] next_stable;
  logic [7:0] next_prev;

  // Per pin: first stage feeds only the second, change compares stage two and three
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      always_comb begin
        next_meta[g] = pin_in[g];
        next_stable[g] = meta[g];
        next_prev[g] = stable[g];
      end
      assign pins.level[g] = stable[g];
      assign pins.change[g] = stable[g] ^ prev[g]; // R14
    end
  endgenerate

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta <= GP_ZERO;
      stable <= GP_ZERO;
      prev <= GP_ZERO;
    end else if (clk_en_in) begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
    end
  end
endmodule

// File: design/gp_port.sv
// Eight-pin general purpose port with modem pin sharing and change interrupts
//
// The register offsets and the plain strobed port were chosen for this implementation.

// What this block does
// R1 - One direction bit per pin; 0 input, 1 output.
// R2 - Writing direction clears any pending pin-change interrupt.
// R3 - Reading pin level returns all eight pin states, honouring latching.
// R4 - Written level drives only pins set as outputs.
// R5 - Per-pin enable lets an input change raise an interrupt.
// R6 - In modem mode enable bits 7..4 are ignored; modem enable governs.
// R7 - Writing control bit 3 resets the device, then reads back zero.
// R8 - Control bit 1 selects upper pins as GPIO or RI, CD, DTR, DSR.
// R9 - Unlatched: change interrupts; level read or pin reverting clears it.
// R10 - Latched: change captured and interrupt held until level is read.
// R11 - GPIO mode: modem status hidden, no modem interrupt, DTR ignores control.
// R12 - Modem mode: status visible, DTR follows control, changes raise interrupt.
// R13 - Modem mode: upper direction, level, enable bits do not touch modem pins.
// R14 - Changes found by synchronised compare; pin interrupt joins device interrupt.
module gp_port import gp_pkg::*; #(
  parameter int PINS = GP_PINS
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_out,
  input wire logic modem_irq_en_in,
  input wire logic modem_dtr_ctrl_in,
  output logic [2:0] modem_status_out,
  output logic soft_reset_out,
  output logic irq_out
);
  gp_pin_if pins ();

  gp_sync #(.PINS(PINS)) u_sync (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .pin_in(pin_in),
    .pins(pins.src)
  );

  // Software visible configuration
  logic [7:0] dir;
  logic [7:0] next_dir;
  logic [7:0] drive;
  logic [7:0] next_drive;
  logic [7:0] ien;
  logic [7:0] next_ien;
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [1:0] imask;
  logic [1:0] next_imask;
  logic soft_reset_trigger;
  logic next_soft_reset_trigger;

  // Per pin interrupt state and the modem change flag
  logic [7:0] pend;
  logic [7:0] next_pend;
  logic [7:0] origin;
  logic [7:0] next_origin;
  logic [7:0] held;
  logic [7:0] next_held;
  logic [7:0] held_v;
  logic [7:0] next_held_v;
  logic modem_ist;
  logic next_modem_ist;

  // Next values of the registered outputs
  logic [7:0] next_rdata;
  logic [7:0] next_pin;
  logic [7:0] next_oe;
  logic [2:0] next_mstat;
  logic next_irq;

  // Decoded strobes and per pin terms
  logic [7:0] gmask;
  logic [7:0] armed;
  logic [7:0] ev;
  logic [7:0] revert;
  logic [7:0] cap;
  logic [7:0] clr;
  logic [7:0] view;
  logic modem_mode;
  logic latch;
  logic rd_level;
  logic wr_dir;
  logic wr_ist;
  logic clr_any;
  logic mev;

  // Shared decode of strobes, modes and pin events
  always_comb begin
    modem_mode = ctrl[GP_CTRL_MODEM];
    latch = ctrl[GP_CTRL_LATCH];
    // Modem mode hides the upper direction, drive and enable bits from the pins
    gmask = modem_mode ? GP_LOW_MASK : GP_ALL_MASK; // R8 R13
    armed = ~dir & ien & gmask; // R5 R6
    ev = pins.change & armed; // R14
    rd_level = rd_in && (addr_in == GP_OFF_LEVEL);
    wr_dir = wr_in && (addr_in == GP_OFF_DIR);
    wr_ist = wr_in && (addr_in == GP_OFF_IST);
    // Pending clears on level read, direction write or W1C; a new event still wins
    clr_any = rd_level || wr_dir || (wr_ist && wdata_in[GP_IST_PIN]); // R2 R9
    clr = clr_any ? GP_ALL_MASK : GP_ZERO;
    revert = latch ? GP_ZERO : (pend & ~(pins.level ^ origin)); // R9
    cap = ev & {PINS{latch}} & (~held_v | clr); // R10
    view = (held & held_v) | (pins.level & ~held_v); // R3
    mev = modem_mode && modem_irq_en_in && |(pins.change & GP_MODEM_IN_MASK); // R11 R12
  end

  // Direction register
  always_comb begin
    next_dir = dir;
    if (wr_dir) begin
      next_dir = wdata_in; // R1
    end
    if (soft_reset_trigger) begin
      next_dir = GP_ZERO; // R7
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dir <= GP_ZERO;
    end else if (clk_en_in) begin
      dir <= next_dir;
    end
  end

  // Output level register; only pins set as outputs ever show it
  always_comb begin
    next_drive = drive;
    if (wr_in && (addr_in == GP_OFF_LEVEL)) begin
      next_drive = wdata_in; // R4
    end
    if (soft_reset_trigger) begin
      next_drive = GP_ZERO;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      drive <= GP_ZERO;
    end else if (clk_en_in) begin
      drive <= next_drive;
    end
  end

  // Pin change interrupt enable register
  always_comb begin
    next_ien = ien;
    if (wr_in && (addr_in == GP_OFF_IEN)) begin
      next_ien = wdata_in; // R5
    end
    if (soft_reset_trigger) begin
      next_ien = GP_ZERO;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ien <= GP_ZERO;
    end else if (clk_en_in) begin
      ien <= next_ien;
    end
  end

  // Interrupt mask register
  always_comb begin
    next_imask = imask;
    if (wr_in && (addr_in == GP_OFF_IMASK)) begin
      next_imask = wdata_in[1:0];
    end
    if (soft_reset_trigger) begin
      next_imask = GP_IST_RESET;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      imask <= GP_IST_RESET;
    end else if (clk_en_in) begin
      imask <= next_imask;
    end
  end

  // Control register; the reset bit is a one-cycle pulse, never stored
  always_comb begin
    next_ctrl = ctrl;
    next_soft_reset_trigger = 1'b0;
    if (wr_in && (addr_in == GP_OFF_CTRL)) begin
      next_ctrl = wdata_in & GP_CTRL_WMASK; // R8
      next_soft_reset_trigger = wdata_in[GP_CTRL_SOFT_RESET_TRIGGER]; // R7
    end
    if (soft_reset_trigger) begin
      next_ctrl = GP_ZERO;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl <= GP_ZERO;
      soft_reset_trigger <= 1'b0;
    end else if (clk_en_in) begin
      ctrl <= next_ctrl;
      soft_reset_trigger <= next_soft_reset_trigger;
    end
  end

  // Per pin pending, origin and latched capture; a new event beats any clear but soft reset
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pend
      always_comb begin
        next_pend[g] = (pend[g] & ~clr[g] & ~revert[g]) | ev[g]; // R9 R10
        next_origin[g] = origin[g];
        if (ev[g] && !pend[g]) begin
          next_origin[g] = ~pins.level[g];
        end
        next_held[g] = cap[g] ? pins.level[g] : held[g];
        next_held_v[g] = (held_v[g] & ~clr[g]) | cap[g]; // R10
        if (soft_reset_trigger) begin
          next_pend[g] = 1'b0;
          next_held_v[g] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pend <= GP_ZERO;
      origin <= GP_ZERO;
      held <= GP_ZERO;
      held_v <= GP_ZERO;
    end else if (clk_en_in) begin
      pend <= next_pend;
      origin <= next_origin;
      held <= next_held;
      held_v <= next_held_v;
    end
  end

  // Sticky modem change flag; a change in the clearing cycle keeps it set
  always_comb begin
    next_modem_ist = modem_ist;
    if (wr_ist && wdata_in[GP_IST_MODEM]) begin
      next_modem_ist = 1'b0;
    end
    if (mev) begin
      next_modem_ist = 1'b1; // R12
    end
    if (soft_reset_trigger) begin
      next_modem_ist = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      modem_ist <= 1'b0;
    end else if (clk_en_in) begin
      modem_ist <= next_modem_ist;
    end
  end

  // Read data stands for one cycle only and is zero otherwise
  always_comb begin
    next_rdata = GP_ZERO;
    if (rd_in) begin
      case (addr_in)
        GP_OFF_DIR: next_rdata = dir;
        GP_OFF_LEVEL: next_rdata = view; // R3
        GP_OFF_IEN: next_rdata = ien;
        GP_OFF_CTRL: next_rdata = ctrl | {4'h0, soft_reset_trigger, 3'h0};
        GP_OFF_IST: next_rdata = {6'h00, modem_ist, |pend};
        GP_OFF_IMASK: next_rdata = {6'h00, imask};
        default: next_rdata = GP_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= GP_ZERO;
    end else if (clk_en_in) begin
      rdata_out <= next_rdata;
    end
  end

  // Outputs drive only where direction says so; DTR taken over in modem mode
  always_comb begin
    next_oe = dir & gmask; // R4 R13
    next_pin = drive & gmask; // R4
    if (modem_mode) begin
      next_oe[GP_DTR_PIN] = 1'b1;
      next_pin[GP_DTR_PIN] = ~modem_dtr_ctrl_in; // R12
    end
    // Modem pins are active low; report asserted as one
    next_mstat = modem_mode ? {~pins.level[GP_RI_PIN], ~pins.level[GP_CD_PIN],
                               ~pins.level[GP_DSR_PIN]} : 3'h0; // R11 R12
    if (soft_reset_trigger) begin
      next_oe = GP_ZERO;
      next_pin = GP_ZERO;
      next_mstat = 3'h0;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_out <= GP_ZERO;
      pin_oe_out <= GP_ZERO;
      modem_status_out <= 3'h0;
    end else if (clk_en_in) begin
      pin_out <= next_pin;
      pin_oe_out <= next_oe;
      modem_status_out <= next_mstat;
    end
  end

  // Interrupt is taken from next values so it rises with the status bit
  always_comb begin
    next_irq = |({next_modem_ist, |next_pend} & next_imask); // R14
    if (soft_reset_trigger) begin
      next_irq = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      soft_reset_out <= 1'b0;
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      soft_reset_out <= next_soft_reset_trigger;
      irq_out <= next_irq;
    end
  end
endmodule

// File: testbench/gp_pin_model.sv
// Outside devices on the eight pins
module gp_pin_model (
  input wire logic [7:0] pin_out_in,
  input wire logic [7:0] pin_oe_in,
  input wire logic [7:0] ext_in,
  output logic [7:0] pin_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven pins read back their own level, the rest follow the outside world
  assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_in);
endmodule

// File: testbench/gp_port_assertions.sv
// Port assertions for the pin port
module gp_port_assertions import gp_pkg::*; (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_out,
  input wire logic [2:0] modem_status_out,
  input wire logic soft_reset_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_wr(a);
    wr_in && addr_in == a;
  endsequence
  sequence s_srst;
    s_wr(GP_OFF_CTRL) ##0 wdata_in[GP_CTRL_SOFT_RESET_TRIGGER];
  endsequence
  AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("rdata outside slot");
  // Output enable and level follow the registers one cycle after they load
  AST_DIR_OE: assert property (s_wr(GP_OFF_DIR) |=> ##1
    pin_oe_out[3:0] == $past(wdata_in[3:0], 2)) else $error("oe not from dir");
  AST_DRIVE: assert property (s_wr(GP_OFF_LEVEL) |=> ##1
    ((pin_out ^ $past(wdata_in, 2)) & pin_oe_out & GP_LOW_MASK) == 8'h00)
    else $error("drive");
  AST_SRST: assert property (s_srst |=> soft_reset_out ##1
    (pin_oe_out == 8'h00 && !irq_out)) else $error("soft reset");
  AST_SRST_CAUSE: assert property ($rose(soft_reset_out) |-> $past(wr_in))
    else $error("stray soft reset");
  AST_SRST_PULSE: assert property (soft_reset_out |=> !soft_reset_out)
    else $error("long soft reset");
  AST_DTR_OE: assert property (modem_status_out != 3'h0 |-> pin_oe_out[GP_DTR_PIN])
    else $error("dtr not driven");
  AST_CTRL_RSV: assert property (rd_in && addr_in == GP_OFF_CTRL |=>
    (rdata_out & 8'hF4) == 8'h00) else $error("reserved bits");
endmodule
bind gp_port gp_port_assertions i_gp_port_assertions (.*);

// File: testbench/tb_gp_port.sv
// Self-checking bench for the pin port
module tb_gp_port import gp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr, rd, mien, dtr, srst, irq;
  logic [3:0] ad;
  logic [7:0] wd, rdat, pin, po, poe, ext;
  logic [2:0] mst;
  int error_cnt = 0;
  int checked = 0;
  logic [19:0] rows [4] = '{{GP_OFF_DIR, 16'hA5A5}, {GP_OFF_CTRL, 16'hF303},
    {GP_OFF_IMASK, 16'hFF03}, {4'hF, 16'h5500}};
  gp_port i_gp_port (.core_clk_in(clk), .reset_in(rst), .clk_en_in(1'b1), .addr_in(ad),
    .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdat), .pin_in(pin), .pin_out(po),
    .pin_oe_out(poe), .modem_irq_en_in(mien), .modem_dtr_ctrl_in(dtr),
    .modem_status_out(mst), .soft_reset_out(srst), .irq_out(irq));
  gp_pin_model i_gp_pin_model (.pin_out_in(po), .pin_oe_in(poe), .ext_in(ext),
    .pin_level_out(pin));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task report_and_stop;
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task c(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      error_cnt++;
    end
  endtask
  task w(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    ad <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task r(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    ad <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 c(rdat, e);
  endtask
  // Sampled at falling edges so the registered irq has settled
  task wi(input logic v);
    @(negedge clk);
    for (int i = 0; i < 8 && irq !== v; i++) @(negedge clk);
    c(8'(irq), 8'(v));
    if (irq !== v) report_and_stop;
  endtask
  initial begin
    rst = 1'b1;
    {wr, rd, mien, dtr, ad, wd, ext} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      w(rows[i][19:16], rows[i][15:8]);
      r(rows[i][19:16], rows[i][7:0]);
    end
    w(GP_OFF_CTRL, 8'h08);
    #1 c(8'(srst), 8'h01);
    @(posedge clk);
    r(GP_OFF_DIR, 8'h00);
    r(GP_OFF_CTRL, 8'h00);
    w(GP_OFF_IMASK, 8'h01);
    w(GP_OFF_IEN, 8'h10);
    @(posedge clk) ext <= 8'h10;
    wi(1'b1);
    r(GP_OFF_LEVEL, 8'h10);
    wi(1'b0);
    @(posedge clk) ext <= 8'h00;
    wi(1'b1);
    @(posedge clk) ext <= 8'h10;
    wi(1'b0);
    @(posedge clk) ext <= 8'h00;
    wi(1'b1);
    w(GP_OFF_DIR, 8'h00);
    wi(1'b0);
    @(posedge clk) ext <= 8'h80;
    repeat (6) @(posedge clk);
    #1 c(8'(irq), 8'h00);
    w(GP_OFF_CTRL, 8'h01);
    @(posedge clk) ext <= 8'h90;
    wi(1'b1);
    @(posedge clk) ext <= 8'h80;
    repeat (5) @(posedge clk);
    #1 c(8'(irq), 8'h01);
    r(GP_OFF_LEVEL, 8'h90);
    wi(1'b0);
    w(GP_OFF_DIR, 8'h0F);
    w(GP_OFF_LEVEL, 8'h05);
    repeat (3) @(posedge clk);
    r(GP_OFF_LEVEL, 8'h85);
    w(GP_OFF_CTRL, 8'h02);
    w(GP_OFF_DIR, 8'hFF);
    w(GP_OFF_IMASK, 8'h03);
    @(posedge clk) {mien, dtr} <= 2'b11;
    repeat (3) @(posedge clk);
    #1 c(poe, 8'h2F);
    c(8'(po[GP_DTR_PIN]), 8'h00);
    c(8'(mst), 8'h03);
    @(posedge clk) ext <= 8'hD0;
    wi(1'b1);
    c(8'(mst), 8'h00);
    r(GP_OFF_IST, 8'h02);
    w(GP_OFF_IST, 8'h02);
    wi(1'b0);
    w(GP_OFF_CTRL, 8'h00);
    @(posedge clk) ext <= 8'h00;
    repeat (6) @(posedge clk);
    #1 c(8'(irq), 8'h00);
    c(8'(mst), 8'h00);
    c(poe, 8'hFF);
    report_and_stop;
  end
endmodule
